// >>> nhr_pkg.sv
// Constants for the network controller host register access block
package nhr_pkg;

  // ----------------------------------------------------------------
  // I/O port addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_WINDOW = 16'h0C60;
  localparam logic [15:0] ADDR_SELECT = 16'h0C62;
  localparam logic [15:0] ALIAS_WINDOW = 16'hC064;
  localparam logic [15:0] ALIAS_SELECT = 16'hC066;
  localparam logic [15:0] ADDR_AUX = 16'h0C68;
  localparam int AUX_LOW_BITS = 3;

  // ----------------------------------------------------------------
  // Internal register indexes behind the window port
  // ----------------------------------------------------------------
  localparam logic [1:0] SEL_CTRL = 2'h0;
  localparam logic [1:0] SEL_ADDR_LOW = 2'h1;
  localparam logic [1:0] SEL_ADDR_HIGH = 2'h2;
  localparam logic [1:0] SEL_MODE = 2'h3;

  // ----------------------------------------------------------------
  // Main control/status field positions
  // ----------------------------------------------------------------
  localparam int B_FAULT = 15;
  localparam int B_OVERLONG = 14;
  localparam int B_HEARTBEAT = 13;
  localparam int B_DROPPED = 12;
  localparam int B_TIMEOUT = 11;
  localparam int B_RX_EVENT = 10;
  localparam int B_TX_EVENT = 9;
  localparam int B_SETUP_DONE = 8;
  localparam int B_INT_PENDING = 7;
  localparam int B_INT_GATE = 6;
  localparam int B_RX_ON = 5;
  localparam int B_TX_ON = 4;
  localparam int B_TX_DEMAND = 3;
  localparam int B_HALT = 2;
  localparam int B_START = 1;
  localparam int B_FETCH = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] RESET_WORD = 16'h0000;
  localparam logic [7:0] RESET_AUX = 8'h00;
  localparam logic [15:0] UNDEF_READ = 16'h0000;

  // ----------------------------------------------------------------
  // Setup block layout and timing
  // ----------------------------------------------------------------
  localparam int SETUP_WORDS = 12;
  localparam logic [3:0] SETUP_LAST = 4'hB;
  localparam int W_MODE = 0;
  localparam int W_RX_RING_LO = 8;
  localparam int W_RX_RING_HI = 9;
  localparam int W_TX_RING_LO = 10;
  localparam int W_TX_RING_HI = 11;
  localparam logic [23:0] WORD_STRIDE = 24'h000002;
  localparam int CLK_PERIOD_NS = 10;
  localparam int BUS_TIMEOUT_NS = 25600;
  localparam int BUS_TIMEOUT_CYC =
    (BUS_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [10:0] OVERLONG_BYTES = 11'd1519;

  // Setup fetch sequencer states
  typedef enum logic [1:0] {
    FS_IDLE,
    FS_ARB,
    FS_XFER
  } nhr_fetch_t;

endpackage : nhr_pkg

// >>> nhr_host_regs.sv
// Host register access, setup fetch and status flags of the controller
`timescale 1ns/100ps
`default_nettype none
module nhr_host_regs (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [15:0] i_io_addr,
  input wire logic i_io_rd,
  input wire logic i_io_wr,
  input wire logic [15:0] i_io_wdata,
  output logic [15:0] o_io_rdata,
  output logic o_io_ready,
  output logic [7:0] o_aux_control,
  output logic o_bus_req,
  input wire logic i_bus_grant,
  output logic o_mem_rd,
  output logic [23:0] o_mem_addr,
  input wire logic i_mem_ready,
  input wire logic [15:0] i_mem_rdata,
  input wire logic i_tx_frame_start,
  input wire logic i_tx_byte,
  input wire logic i_heartbeat_fault,
  input wire logic i_dropped_frame,
  input wire logic i_rx_event,
  input wire logic i_tx_event,
  input wire logic i_tx_demand_ack,
  output logic o_rings_active,
  output logic o_receiver_on,
  output logic o_transmitter_on,
  output logic o_transmit_demand,
  output logic [15:0] o_mode,
  output logic [23:0] o_rx_ring_addr,
  output logic [23:0] o_tx_ring_addr,
  output logic o_interrupt
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [15:0] select_reg;
  logic [15:0] addr_low_reg;
  logic [15:0] addr_high_reg;
  logic [15:0] mode_reg;
  logic [7:0] aux_reg;
  logic halt_reg;
  logic start_reg;
  logic fetch_reg;
  logic gate_reg;
  logic demand_reg;
  logic rx_on_reg;
  logic tx_on_reg;
  logic active_reg;
  logic [6:0] flag_reg;
  logic [6:0] flag_set;
  logic [6:0] flag_clr;
  logic [15:0] status_word;
  logic [15:0] rdata_reg;
  logic ready_reg;
  logic [15:0] setup_mem_reg [nhr_pkg::SETUP_WORDS];
  nhr_pkg::nhr_fetch_t fstate_reg;
  logic [3:0] word_idx_reg;
  logic [23:0] mem_addr_reg;
  logic [11:0] wait_cnt_reg;
  logic [10:0] byte_cnt_reg;
  logic overlong_seen_reg;
  logic hit_window;
  logic hit_select;
  logic hit_aux;
  logic wr_window;
  logic wr_ctrl;
  logic halt_cmd;
  logic go_cmd;
  logic fetch_done;
  logic timeout;
  logic overlong_hit;

  // Port decode shared by reads and writes
  function automatic logic port_hit(input logic [15:0] addr,
                                    input logic [15:0] prim,
                                    input logic [15:0] alias_a);
    port_hit = (addr == prim) || (addr == alias_a);
  endfunction : port_hit

  // ----------------------------------------------------------------
  // I/O decode
  // ----------------------------------------------------------------
  // primary and alias ports
  assign hit_window = port_hit(i_io_addr, nhr_pkg::ADDR_WINDOW,
                               nhr_pkg::ALIAS_WINDOW);
  assign hit_select = port_hit(i_io_addr, nhr_pkg::ADDR_SELECT,
                               nhr_pkg::ALIAS_SELECT);
  assign hit_aux = (i_io_addr[15:nhr_pkg::AUX_LOW_BITS] ==
                    nhr_pkg::ADDR_AUX[15:nhr_pkg::AUX_LOW_BITS]);
  assign wr_window = i_io_wr && hit_window;
  // two select bits pick the register
  assign wr_ctrl = wr_window && (select_reg[1:0] == nhr_pkg::SEL_CTRL);
  assign halt_cmd = wr_ctrl && i_io_wdata[nhr_pkg::B_HALT];
  assign go_cmd = wr_ctrl && !i_io_wdata[nhr_pkg::B_HALT] &&
                  (i_io_wdata[nhr_pkg::B_START] ||
                   i_io_wdata[nhr_pkg::B_FETCH]);

  // ----------------------------------------------------------------
  // Select port
  // ----------------------------------------------------------------
  // index held until rewritten, cleared by halt or reset
  always_ff @(posedge i_clk) begin
    if (i_reset || halt_cmd) begin
      select_reg <= nhr_pkg::RESET_WORD;
    end else if (i_io_wr && hit_select) begin
      select_reg <= i_io_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Registers 1 to 3
  // ----------------------------------------------------------------
  // written only while halted, otherwise ignored
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      addr_low_reg <= nhr_pkg::RESET_WORD;
      addr_high_reg <= nhr_pkg::RESET_WORD;
      mode_reg <= nhr_pkg::RESET_WORD;
    end else if (wr_window && halt_reg) begin
      unique case (select_reg[1:0])
        nhr_pkg::SEL_ADDR_LOW: addr_low_reg <= i_io_wdata;
        nhr_pkg::SEL_ADDR_HIGH: addr_high_reg <= i_io_wdata;
        nhr_pkg::SEL_MODE: mode_reg <= i_io_wdata;
        nhr_pkg::SEL_CTRL: ;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      aux_reg <= nhr_pkg::RESET_AUX;
    end else if (i_io_wr && hit_aux) begin
      aux_reg <= i_io_wdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Control bits of register 0
  // ----------------------------------------------------------------
  // come up halted; halt wins over start and fetch
  always_ff @(posedge i_clk) begin
    if (i_reset || halt_cmd) begin
      halt_reg <= 1'b1;
      start_reg <= 1'b0;
      fetch_reg <= 1'b0;
      gate_reg <= 1'b0;
    end else begin
      if (go_cmd) begin
        halt_reg <= 1'b0;
      end
      if (go_cmd && i_io_wdata[nhr_pkg::B_START]) begin
        start_reg <= 1'b1;
      end
      if (go_cmd && i_io_wdata[nhr_pkg::B_FETCH]) begin
        fetch_reg <= 1'b1;
      end
      if (wr_ctrl) begin
        gate_reg <= i_io_wdata[nhr_pkg::B_INT_GATE];
      end
    end
  end

  // Transmit demand held until the transmitter takes it
  always_ff @(posedge i_clk) begin
    if (i_reset || halt_cmd) begin
      demand_reg <= 1'b0;
    end else if (wr_ctrl && i_io_wdata[nhr_pkg::B_TX_DEMAND]) begin
      demand_reg <= 1'b1;
    end else if (i_tx_demand_ack) begin
      demand_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Setup fetch as bus master
  // ----------------------------------------------------------------
  assign timeout = (fstate_reg == nhr_pkg::FS_XFER) && !i_mem_ready &&
                   (wait_cnt_reg == 12'(nhr_pkg::BUS_TIMEOUT_CYC - 1));
  assign fetch_done = (fstate_reg == nhr_pkg::FS_XFER) && i_mem_ready &&
                      (word_idx_reg == nhr_pkg::SETUP_LAST);

  // word walk over the setup block after grant
  always_ff @(posedge i_clk) begin
    if (i_reset || halt_cmd) begin
      fstate_reg <= nhr_pkg::FS_IDLE;
      word_idx_reg <= 4'h0;
      mem_addr_reg <= 24'h000000;
      wait_cnt_reg <= 12'h000;
    end else begin
      unique case (fstate_reg)
        nhr_pkg::FS_IDLE: begin
          if (go_cmd && i_io_wdata[nhr_pkg::B_FETCH]) begin
            fstate_reg <= nhr_pkg::FS_ARB;
            word_idx_reg <= 4'h0;
            // full byte address, no alignment forced
            mem_addr_reg <= {addr_high_reg[7:0], addr_low_reg};
          end
        end
        nhr_pkg::FS_ARB: begin
          wait_cnt_reg <= 12'h000;
          if (i_bus_grant) begin
            fstate_reg <= nhr_pkg::FS_XFER;
          end
        end
        nhr_pkg::FS_XFER: begin
          if (timeout) begin
            fstate_reg <= nhr_pkg::FS_IDLE;
          end else if (i_mem_ready) begin
            setup_mem_reg[word_idx_reg] <= i_mem_rdata;
            wait_cnt_reg <= 12'h000;
            mem_addr_reg <= mem_addr_reg + nhr_pkg::WORD_STRIDE;
            word_idx_reg <= word_idx_reg + 4'h1;
            if (fetch_done) begin
              fstate_reg <= nhr_pkg::FS_IDLE;
            end
          end else begin
            wait_cnt_reg <= wait_cnt_reg + 12'h001;
          end
        end
        default: begin
          fstate_reg <= nhr_pkg::FS_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Ring activity and transceiver enables
  // ----------------------------------------------------------------
  // rings run on their own once started; timeout stops them
  always_ff @(posedge i_clk) begin
    if (i_reset || halt_cmd || timeout) begin
      active_reg <= 1'b0;
      rx_on_reg <= 1'b0;
      tx_on_reg <= 1'b0;
    end else if ((fetch_done && start_reg) ||
                 (go_cmd && i_io_wdata[nhr_pkg::B_START] &&
                  !i_io_wdata[nhr_pkg::B_FETCH] &&
                  fstate_reg == nhr_pkg::FS_IDLE)) begin
      active_reg <= 1'b1;
      rx_on_reg <= 1'b1;
      tx_on_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Overlong frame detection
  // ----------------------------------------------------------------
  // Hit on the byte that brings the frame to the overlong count
  assign overlong_hit = i_tx_byte && !overlong_seen_reg &&
                        (byte_cnt_reg == nhr_pkg::OVERLONG_BYTES - 11'd1);

  // count bytes of the current frame
  always_ff @(posedge i_clk) begin
    if (i_reset || i_tx_frame_start) begin
      byte_cnt_reg <= 11'd0;
      overlong_seen_reg <= 1'b0;
    end else if (i_tx_byte && !overlong_seen_reg) begin
      byte_cnt_reg <= byte_cnt_reg + 11'd1;
      overlong_seen_reg <= overlong_hit;
    end
  end

  // ----------------------------------------------------------------
  // Event flags, bits 14 down to 8
  // ----------------------------------------------------------------
  assign flag_set = {overlong_hit, i_heartbeat_fault, i_dropped_frame,
                     timeout, i_rx_event, i_tx_event, fetch_done};
  assign flag_clr = wr_ctrl ? i_io_wdata[14:8] : 7'h00;

  // write one clears, set wins, halt and reset clear
  always_ff @(posedge i_clk) begin
    if (i_reset || halt_cmd) begin
      flag_reg <= 7'h00;
    end else begin
      flag_reg <= (flag_reg & ~flag_clr) | flag_set;
    end
  end

  // ----------------------------------------------------------------
  // Status word and read path
  // ----------------------------------------------------------------
  // register 0 layout with fault summary
  assign status_word = {|flag_reg[6:3], flag_reg, |flag_reg, gate_reg,
                        rx_on_reg, tx_on_reg, demand_reg, halt_reg,
                        start_reg, fetch_reg};

  // registered answer one cycle after a strobe to a decoded port
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      rdata_reg <= nhr_pkg::RESET_WORD;
      ready_reg <= 1'b0;
    end else begin
      ready_reg <= (i_io_rd || i_io_wr) && (hit_window || hit_select ||
                                            hit_aux);
      if (i_io_rd && hit_select) begin
        rdata_reg <= select_reg;
      end else if (i_io_rd && hit_window) begin
        unique case (select_reg[1:0])
          nhr_pkg::SEL_CTRL: rdata_reg <= status_word;
          nhr_pkg::SEL_ADDR_LOW: rdata_reg <= halt_reg ? addr_low_reg :
                                              nhr_pkg::UNDEF_READ;
          nhr_pkg::SEL_ADDR_HIGH: rdata_reg <= halt_reg ? addr_high_reg :
                                               nhr_pkg::UNDEF_READ;
          nhr_pkg::SEL_MODE: rdata_reg <= halt_reg ? mode_reg :
                                          nhr_pkg::UNDEF_READ;
        endcase
      end else if (i_io_rd) begin
        rdata_reg <= nhr_pkg::UNDEF_READ;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_io_rdata = rdata_reg;
  assign o_io_ready = ready_reg;
  assign o_aux_control = aux_reg;
  assign o_bus_req = (fstate_reg != nhr_pkg::FS_IDLE);
  assign o_mem_rd = (fstate_reg == nhr_pkg::FS_XFER);
  assign o_mem_addr = mem_addr_reg;
  assign o_rings_active = active_reg;
  assign o_receiver_on = rx_on_reg;
  assign o_transmitter_on = tx_on_reg;
  assign o_transmit_demand = demand_reg;
  assign o_mode = setup_mem_reg[nhr_pkg::W_MODE];
  // ring bases handed to the ring engine
  assign o_rx_ring_addr = {setup_mem_reg[nhr_pkg::W_RX_RING_HI][7:0],
                           setup_mem_reg[nhr_pkg::W_RX_RING_LO]};
  assign o_tx_ring_addr = {setup_mem_reg[nhr_pkg::W_TX_RING_HI][7:0],
                           setup_mem_reg[nhr_pkg::W_TX_RING_LO]};
  // pending request gated onto the line
  assign o_interrupt = gate_reg && (|flag_reg);

endmodule : nhr_host_regs
`default_nettype wire

// >>> nhr_host_regs_sva.sv
// Concurrent checks on the host register access ports
`timescale 1ns/100ps
`default_nettype none
module nhr_host_regs_sva (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [15:0] i_io_addr,
  input wire logic i_io_rd,
  input wire logic i_io_wr,
  input wire logic [15:0] i_io_wdata,
  input wire logic [15:0] o_io_rdata,
  input wire logic o_io_ready,
  input wire logic [7:0] o_aux_control,
  input wire logic o_bus_req,
  input wire logic i_bus_grant,
  input wire logic o_mem_rd,
  input wire logic [23:0] o_mem_addr,
  input wire logic i_mem_ready
);
  logic win;
  logic selp;
  logic auxp;
  logic hit;
  logic w0;
  logic [1:0] sel_reg;
  logic rd0_reg;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_reset);
  // ----------------------------------------
  // Port decode and index tracking
  // ----------------------------------------
  assign win = i_io_addr == nhr_pkg::ADDR_WINDOW ||
    i_io_addr == nhr_pkg::ALIAS_WINDOW;
  assign selp = i_io_addr == nhr_pkg::ADDR_SELECT ||
    i_io_addr == nhr_pkg::ALIAS_SELECT;
  assign auxp = (i_io_addr & 16'hFFF8) == nhr_pkg::ADDR_AUX;
  assign hit = (i_io_rd || i_io_wr) && (win || selp || auxp);
  assign w0 = i_io_wr && win && sel_reg == nhr_pkg::SEL_CTRL;
  // Follows the selected index, cleared by reset or halt
  always_ff @(posedge i_clk) begin
    rd0_reg <= !i_reset && i_io_rd && win && sel_reg == nhr_pkg::SEL_CTRL;
    if (i_reset) sel_reg <= 2'h0;
    else if (i_io_wr && selp) sel_reg <= i_io_wdata[1:0];
    else if (w0 && i_io_wdata[nhr_pkg::B_HALT]) sel_reg <= 2'h0;
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  chk_ready_on_hit: assert property (hit |=> o_io_ready)
    else $error("no ready after a decoded access");
  chk_ready_only_hit: assert property (!hit |=> !o_io_ready)
    else $error("ready without a decoded access");
  chk_fault_sum: assert property (
    rd0_reg |-> o_io_rdata[15] == |o_io_rdata[14:11])
    else $error("fault summary bit wrong");
  chk_pending_sum: assert property (
    rd0_reg |-> o_io_rdata[7] == |o_io_rdata[14:8])
    else $error("interrupt pending bit wrong");
  chk_fetch_request: assert property (
    w0 && i_io_wdata[0] && !i_io_wdata[2] && !o_bus_req |=> o_bus_req)
    else $error("setup fetch did not request the bus");
  chk_read_granted: assert property (
    o_mem_rd |-> o_bus_req && $past(i_bus_grant))
    else $error("memory read without grant");
  chk_addr_step: assert property (
    o_mem_rd && i_mem_ready ##1 o_mem_rd |->
    o_mem_addr == $past(o_mem_addr) + nhr_pkg::WORD_STRIDE)
    else $error("setup address did not step");
  chk_aux_write: assert property (
    i_io_wr && auxp |=> o_aux_control == $past(i_io_wdata[7:0]))
    else $error("aux register not written");
  chk_rdata_hold: assert property (!i_io_rd |=> $stable(o_io_rdata))
    else $error("read data changed without a read");
  // Main scenarios reached
  cov_fetch_end: cover property (o_bus_req ##1 !o_bus_req);
  cov_ctrl_read: cover property (rd0_reg);
  cov_word: cover property (o_mem_rd && i_mem_ready);
endmodule : nhr_host_regs_sva
bind nhr_host_regs nhr_host_regs_sva u_nhr_host_regs_sva (
  .i_clk(i_clk), .i_reset(i_reset), .i_io_addr(i_io_addr),
  .i_io_rd(i_io_rd), .i_io_wr(i_io_wr), .i_io_wdata(i_io_wdata),
  .o_io_rdata(o_io_rdata), .o_io_ready(o_io_ready),
  .o_aux_control(o_aux_control), .o_bus_req(o_bus_req),
  .i_bus_grant(i_bus_grant), .o_mem_rd(o_mem_rd),
  .o_mem_addr(o_mem_addr), .i_mem_ready(i_mem_ready));
`default_nettype wire

// >>> nhr_mem_model.sv
// System bus arbiter and memory seen by the controller
`timescale 1ns/100ps
`default_nettype none
module nhr_mem_model (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_bus_req,
  input wire logic i_mem_rd,
  input wire logic [23:0] i_mem_addr,
  input wire logic i_mute,
  output logic o_grant,
  output logic o_ready,
  output logic [15:0] o_rdata
);
  int gap;
  // bus grant
  // Grant after a random wait, held until the request drops
  always_ff @(posedge i_clk) begin
    if (i_reset || !i_bus_req) o_grant <= 1'b0;
    else if ($urandom % 3 == 0) o_grant <= 1'b1;
  end
  // memory words
  // One word per pulse, quadword aligned; data toggles when idle
  always_ff @(posedge i_clk) begin
    o_ready <= 1'b0;
    o_rdata <= ~o_rdata;
    if (i_reset) begin
      gap <= 2;
      o_rdata <= 16'h0000;
    end else if (gap > 0) begin
      gap <= gap - 1;
    end else if (i_mem_rd && o_grant && !i_mute && !o_ready) begin
      o_ready <= 1'b1;
      o_rdata <= {i_mem_addr[12:0] ^ 13'h0B47, 3'h0};
      gap <= $urandom % 3;
    end
  end
endmodule : nhr_mem_model
`default_nettype wire

// >>> nhr_host_regs_tb.sv
// Self-checking testbench of the host register access block
`timescale 1ns/100ps
`default_nettype none
module nhr_host_regs_tb;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic [15:0] io_addr = 16'h0000;
  logic [15:0] io_wdata = 16'h0000;
  logic io_rd = 1'b0, io_wr = 1'b0, mute = 1'b0;
  logic frame = 1'b0, txb = 1'b0, ack = 1'b0;
  logic [3:0] ev = 4'h0;
  logic io_ready, bus_req, grant, mem_rd, mem_ready;
  logic active, rx_on, tx_on, demand, irq;
  logic [7:0] aux;
  logic [23:0] mem_addr, rx_ring, tx_ring, base;
  logic [15:0] io_rdata, mem_rdata, mode, rd;
  int n_errors = 0, checked = 0, i;
  int model [4];
  int evb [4] = '{9, 10, 12, 13};
  always #5 i_clk = ~i_clk;
  nhr_host_regs u_nhr_host_regs (.i_clk(i_clk), .i_reset(i_reset),
    .i_io_addr(io_addr), .i_io_rd(io_rd), .i_io_wr(io_wr),
    .i_io_wdata(io_wdata), .o_io_rdata(io_rdata), .o_io_ready(io_ready),
    .o_aux_control(aux), .o_bus_req(bus_req), .i_bus_grant(grant),
    .o_mem_rd(mem_rd), .o_mem_addr(mem_addr), .i_mem_ready(mem_ready),
    .i_mem_rdata(mem_rdata), .i_tx_frame_start(frame), .i_tx_byte(txb),
    .i_heartbeat_fault(ev[3]), .i_dropped_frame(ev[2]),
    .i_rx_event(ev[1]), .i_tx_event(ev[0]), .i_tx_demand_ack(ack),
    .o_rings_active(active), .o_receiver_on(rx_on),
    .o_transmitter_on(tx_on), .o_transmit_demand(demand), .o_mode(mode),
    .o_rx_ring_addr(rx_ring), .o_tx_ring_addr(tx_ring), .o_interrupt(irq));
  nhr_mem_model u_nhr_mem_model (.i_clk(i_clk), .i_reset(i_reset),
    .i_bus_req(bus_req), .i_mem_rd(mem_rd), .i_mem_addr(mem_addr),
    .i_mute(mute), .o_grant(grant), .o_ready(mem_ready),
    .o_rdata(mem_rdata));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string s, input logic [31:0] e,
    input logic [31:0] g);
    checked++;
    if (e !== g) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  // One strobed access; ready expected one cycle later
  task automatic io(input logic w, input logic [15:0] a,
    input logic [15:0] d, input logic r);
    @(posedge i_clk);
    io_addr <= a;
    io_wr <= w;
    io_rd <= !w;
    io_wdata <= d;
    @(posedge i_clk);
    io_wr <= 1'b0;
    io_rd <= 1'b0;
    #1;
    chk("ready", r, io_ready);
    rd = io_rdata;
  endtask : io
  task automatic wsel(input logic [15:0] d);
    io(1'b1, nhr_pkg::ADDR_SELECT, d, 1'b1);
  endtask : wsel
  task automatic wwin(input logic [15:0] d);
    io(1'b1, nhr_pkg::ADDR_WINDOW, d, 1'b1);
  endtask : wwin
  task automatic rwin();
    io(1'b0, nhr_pkg::ADDR_WINDOW, 16'h0000, 1'b1);
  endtask : rwin
  // One-cycle pulse: 0..3 event pins, 4 frame start, 5 byte, 6 demand ack
  task automatic pulse(input int k);
    @(posedge i_clk);
    ev <= (k < 4) ? 4'(1 << k) : 4'h0;
    frame <= (k == 4);
    txb <= (k == 5);
    ack <= (k == 6);
    @(posedge i_clk);
    ev <= 4'h0;
    frame <= 1'b0;
    txb <= 1'b0;
    ack <= 1'b0;
  endtask : pulse
  function automatic logic [15:0] word(input logic [23:0] a);
    return {a[12:0] ^ 13'h0B47, 3'h0};
  endfunction : word
  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude
  // Watchdog against a hang
  initial begin
    #400000;
    n_errors++;
    conclude();
  end
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'h81AE3822));
    repeat (16) @(posedge i_clk);
    i_reset <= 1'b0;
    rwin();
    chk("reg0", 16'h0004, rd);
    io(1'b0, nhr_pkg::ALIAS_SELECT, 16'h0000, 1'b1);
    chk("select", 16'h0000, rd);
    // Halted: registers 1..3 hold random data, upper index bits ignored
    for (i = 1; i < 4; i++) begin
      model[i] = $urandom & 32'hFFFF;
      wsel(16'hFFFC | 16'(i));
      wwin(16'(model[i]));
      io(1'b0, nhr_pkg::ADDR_SELECT, 16'h0000, 1'b1);
      chk("select", 16'hFFFC | 16'(i), rd);
    end
    for (i = 1; i < 4; i++) begin
      wsel(16'(i));
      rwin();
      chk("reg", model[i], rd);
      rwin();
      chk("reg", model[i], rd);
    end
    io(1'b1, nhr_pkg::ALIAS_SELECT, 16'h0002, 1'b1);
    io(1'b0, nhr_pkg::ALIAS_WINDOW, 16'h0000, 1'b1);
    chk("alias", model[2], rd);
    // Aux port over its whole range, write-only
    for (i = 0; i < 8; i++) begin
      io(1'b1, nhr_pkg::ADDR_AUX + 16'(i), 16'($urandom), 1'b1);
      chk("aux", io_wdata[7:0], aux);
    end
    io(1'b0, nhr_pkg::ADDR_AUX, 16'h0000, 1'b1);
    chk("aux read", 16'h0000, rd);
    io(1'b0, 16'h0C64, 16'h0000, 1'b0);
    // Bring-up: even setup address in registers 1 and 2, then fetch and start
    // normal bring-up keeps to the primary ports
    base = 24'($urandom) & 24'hFFFFFE;
    wsel(16'h0001);
    wwin(base[15:0]);
    wsel(16'h0002);
    wwin({8'hA5, base[23:16]});
    wsel(16'h0000);
    wwin(16'h0003);
    repeat (300) if (!active) @(posedge i_clk);
    #1;
    chk("active", 1'b1, {active, rx_on, tx_on} == 3'h7);
    chk("mode", word(base), mode);
    chk("rx ring", {word(base + 24'd18), word(base + 24'd16)}
      & 32'h00FFFFFF, rx_ring);
    chk("tx ring", {word(base + 24'd22), word(base + 24'd20)}
      & 32'h00FFFFFF, tx_ring);
    rwin();
    chk("reg0", 16'h01B2, rd & 16'h81B6);
    // Running: register 1 answers but stays shut
    wsel(16'h0001);
    rwin();
    chk("reg1 run", nhr_pkg::UNDEF_READ, rd);
    wwin(16'h1234);
    wsel(16'h0000);
    // Each of the four event pin flags sets, then clears by writing one
    for (i = 0; i < 4; i++) begin
      pulse(i);
      rwin();
      chk("flag", {1'b1, 1'(i > 1)}, {rd[evb[i]], rd[15]});
      wwin(16'h0001 << evb[i]);
      rwin();
      chk("flag clr", 1'b0, rd[evb[i]]);
    end
    // Gate on and setup-done cleared, so only the receive event can request
    wwin(16'h0140);
    chk("irq", 1'b0, irq);
    pulse(1);
    @(posedge i_clk);
    #1;
    chk("irq", 1'b1, irq);
    wwin(16'h0440);
    chk("irq", 1'b0, irq);
    wwin(16'h0008);
    chk("demand", 1'b1, demand);
    pulse(6);
    #1;
    chk("demand", 1'b0, demand);
    // Overlong frame at the exact byte count
    pulse(4);
    repeat (1518) pulse(5);
    rwin();
    chk("overlong", 1'b0, rd[14]);
    pulse(5);
    rwin();
    chk("overlong", 16'hC000, rd & 16'hC000);
    wwin(16'h4000);
    rwin();
    chk("overlong clr", 1'b0, rd[14]);
    // Halt: select port clears, registers reopen, running write lost
    wsel(16'hFFFC);
    wwin(16'h0004);
    chk("halted", 3'h0, {active, rx_on, tx_on});
    io(1'b0, nhr_pkg::ADDR_SELECT, 16'h0000, 1'b1);
    chk("select", 16'h0000, rd);
    wsel(16'h0001);
    rwin();
    chk("reg1", base[15:0], rd);
    // Memory never answers: bus timeout ends the fetch
    mute <= 1'b1;
    wsel(16'h0000);
    wwin(16'h0001);
    repeat (2700) @(posedge i_clk);
    rwin();
    chk("timeout", 16'h8800, rd & 16'h8800);
    chk("bus req", 1'b0, bus_req);
    mute <= 1'b0;
    conclude();
  end
endmodule : nhr_host_regs_tb
`default_nettype wire
